// file: test/cdtf_checker.sv
// Checker of the divider outputs
`timescale 1ns/1ns
module cdtf_checker(input wire sys_clk, reset_n, clk_in_p, clk_in_n, clk_in_open,
    out_gate, out_gate_open, master_clear_n, master_clear_open, ratio_sel,
    ratio_sel_open, q_true, q_comp);
    // Resolved pin levels; open pins read high
    wire clr = !master_clear_n && !master_clear_open;
    wire g = out_gate || out_gate_open;
    wire ok = !clr && g;
    wire off = !clr && !g;
    wire r5 = ratio_sel || ratio_sel_open;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_up; $rose(q_true) ##1 ok; endsequence
    property p_pair; q_comp != q_true; endproperty
    property p_clr; clr[*4] |-> !q_true && q_comp; endproperty
    property p_rst; clr[*4] ##1 !clr |=> !q_true[*3]; endproperty
    property p_off; off[*8] ##1 off[*8] |-> !q_true; endproperty
    property p_dead; (clk_in_p == clk_in_n && !clr)[*6] |-> $stable(q_true); endproperty
    property p_open; (clk_in_open && !clr)[*6] |-> $stable(q_true); endproperty
    property p_by5; s_up ##0 (ok && r5)[*8] |-> q_true; endproperty
    property p_by3; s_up ##0 (ok && !r5)[*8] |-> !q_true; endproperty
    a_pair: assert property (p_pair) else $error("pair");
    a_clr: assert property (p_clr) else $error("clear");
    a_rst: assert property (p_rst) else $error("restart");
    a_off: assert property (p_off) else $error("gate off");
    a_dead: assert property (p_dead) else $error("dead");
    a_open: assert property (p_open) else $error("open");
    a_by5: assert property (p_by5) else $error("by five");
    a_by3: assert property (p_by3) else $error("by three");
endmodule
bind cdtf_divider cdtf_checker i_chk(.sys_clk, .reset_n, .clk_in_p, .clk_in_n,
    .clk_in_open, .out_gate, .out_gate_open, .master_clear_n, .master_clear_open,
    .ratio_sel, .ratio_sel_open, .q_true, .q_comp);

// file: test/cdtf_clk_src.sv
// Model of the differential clock source
`timescale 1ns/1ns
module cdtf_clk_src(input wire sys_clk, run, dead, input wire [1:0] half,
    output reg p = 0, output reg n = 1);
    reg [1:0] cnt = 0;
    // Toggles every half cycles; dead makes both legs move together
    always @(posedge sys_clk) begin
        cnt <= run && cnt != half - 2'h1 ? cnt + 2'h1 : 2'h0;
        if (run && cnt == half - 2'h1) begin p <= !p; n <= dead ? !p : p; end
        else n <= dead ? p : !p;
    end
endmodule

// file: test/cdtf_divider_tb.sv
// Testbench of the divider
`timescale 1ns/1ns
module cdtf_divider_tb;
    reg sys_clk = 0, reset_n = 0, in_open = 0, gate = 1, clr_n = 1, ratio = 0;
    reg ratio_open = 0, run = 0, dead = 0, s, gate_open = 0, clr_open = 0;
    reg [1:0] half = 2;
    wire p, n, q_true, q_comp;
    integer n_fail = 0, n_checks = 0, k;
    always #20 sys_clk = !sys_clk;
    cdtf_clk_src i_cdtf_clk_src(.sys_clk(sys_clk), .run(run), .dead(dead), .half(half),
        .p(p), .n(n));
    cdtf_divider i_cdtf_divider(.sys_clk(sys_clk), .reset_n(reset_n), .clk_in_p(p),
        .clk_in_n(n), .clk_in_open(in_open), .out_gate(gate), .out_gate_open(gate_open),
        .master_clear_n(clr_n), .master_clear_open(clr_open), .ratio_sel(ratio),
        .ratio_sel_open(ratio_open), .q_true(q_true), .q_comp(q_comp));
    task cyc(input integer c); repeat (c) @(posedge sys_clk); #1; endtask
    task chk(input ok);
        n_checks++;
        if (ok !== 1'b1) begin n_fail++; $display("CHECK FAILED %0t output", $time); end
    endtask
    task w_hi;
        k = 0;
        while (q_true !== 1'b1 && k < 200) begin cyc(1); k++; end
        chk(k < 200);
    endtask
    // Measures one whole high pulse
    task hi_len(input integer e);
        k = 0;
        while (q_true === 1'b1 && k < 200) begin cyc(1); k++; end
        w_hi;
        k = 0;
        while (q_true === 1'b1 && k < 200) begin cyc(1); k++; end
        chk(k == e);
    endtask
    task t_ratio(input r, input ro, input [1:0] h, input integer e);
        clr_n = 0; cyc(5); ratio = r; ratio_open = ro; half = h; clr_n = 1; cyc(40);
        hi_len(e);
    endtask
    task t_clear;
        w_hi; run = 0; clr_n = 0; cyc(4); chk(q_true === 1'b0 && q_comp === 1'b1);
        clr_n = 1; run = 1; hi_len(6);
    endtask
    task t_gate;
        gate = 0; cyc(30); chk(q_true === 1'b0 && q_comp === 1'b1);
        gate = 1; hi_len(6);
    endtask
    task t_dead;
        w_hi; dead = 1; cyc(30); chk(q_true === 1'b1); dead = 0;
        in_open = 1; cyc(6); s = q_true; cyc(30); chk(q_true === s); in_open = 0;
    endtask
    // Open gate and clear pins override driven lows
    task t_pins;
        gate_open = 1; clr_open = 1; gate = 0; clr_n = 0; cyc(30);
        hi_len(10);
        gate = 1; clr_n = 1; gate_open = 0; clr_open = 0;
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(4); reset_n = 1; run = 1;
        t_ratio(0, 0, 2, 6);
        t_clear;
        t_gate;
        t_ratio(1, 0, 3, 15);
        t_ratio(0, 1, 2, 10);
        t_pins;
        t_dead;
        wrap_up;
    end
    // Watchdog
    initial begin #200000; n_fail++; wrap_up; end
endmodule

// file: verilog/cdtf_consts.vh
// Constants for the divide-by-three or five clock divider
// Summary of operation
// - Ratio select low divides input clock by three, high divides by five.
// - Unconnected gate, clear and ratio inputs read high: enabled, not cleared, by five.
// - Gate low with clear inactive holds true output low, complement high.
// - Gate changes take effect only after one input rise and one input fall.
// - Clear low forces true output low, complement high, without input clock edges.
// - Collapsed input swing keeps the output stable; removed swing adds at most one counted rise, then holds.
// - Unconnected differential input pair reads as a steady valid level.
`ifndef CDTF_CONSTS_VH
`define CDTF_CONSTS_VH

// Division ratios, counted in input half periods per output half period
`define CDTF_DIV_LOW         3
`define CDTF_DIV_HIGH        5
`define CDTF_CNT_W           3

// Last half-period count before the output toggles: ratio minus one
`define CDTF_LAST_LOW        3'h2
`define CDTF_LAST_HIGH       3'h4

// Reset values
`define CDTF_RST_TRUE_OUT    1'h0
`define CDTF_RST_COMP_OUT    1'h1
`define CDTF_RST_LEVEL       1'h1
`define CDTF_RST_GATE        1'h1
`define CDTF_RST_CNT         3'h0
// Synchroniser reset: legs equal (no edge), not open, other pins at open level
`define CDTF_RST_SYNC        6'h37

// Level taken by a pin that is left unconnected
`define CDTF_OPEN_LEVEL      1'h1

`endif

// file: verilog/cdtf_divider.v
// Divide-by-three or five clock divider with gate and master clear
`timescale 1ns/1ns
`include "cdtf_consts.vh"

module cdtf_divider
(
    input  wire sys_clk,
    input  wire reset_n,
    input  wire clk_in_p,
    input  wire clk_in_n,
    input  wire clk_in_open,
    input  wire out_gate,
    input  wire out_gate_open,
    input  wire master_clear_n,
    input  wire master_clear_open,
    input  wire ratio_sel,
    input  wire ratio_sel_open,
    output reg  q_true,
    output reg  q_comp
);

    ////////////////////////////////////////////////////////////////////////////
    // How the block works, and what to watch for:
    // - Every pin passes two flip-flops; the input pair then passes the guard
    //   flip-flop, so an input edge reaches the outputs four clock edges later.
    // - The input clock must hold each level for at least one system clock;
    //   faster inputs lose edges in the synchroniser.
    // - Both edges of the input clock are counted, so the output toggles every
    //   three or five input edges and keeps an even duty cycle.
    // - A gate change waits for an input rise and then an input fall; with the
    //   input clock stopped or open, a pending change never lands.
    // - Clear acts through the synchroniser, three system clocks after the pin
    //   falls, and needs no input clock edge at all.
    // - A ratio change in mid-count is safe: the compare uses greater-or-equal,
    //   so a count above the new limit toggles on the next input edge instead of locking up.

    // Gate-change sequencer states
    localparam [1:0] GS_STEADY    = 2'h0;           // Applied gate matches the pin
    localparam [1:0] GS_WAIT_RISE = 2'h1;           // Change pending, no rise yet
    localparam [1:0] GS_WAIT_FALL = 2'h2;           // Rise seen, lands on a fall

    reg  [`CDTF_CNT_W-1:0] cnt_q;
    reg  [`CDTF_CNT_W-1:0] cnt_d;
    reg                    div_q;
    reg                    div_d;
    reg                    gate_q;
    reg                    gate_d;
    reg  [1:0]             gs_q;
    reg  [1:0]             gs_d;
    reg  [5:0]             sync1_q;
    reg  [5:0]             sync2_q;
    wire                   gate_want;
    wire                   clear_act;
    wire                   ratio_hi;
    wire                   in_rise;
    wire                   in_fall;
    wire                   edge_any;

    // Last half-period count before the output toggles
    function [`CDTF_CNT_W-1:0] last_count;
        input sel;
        begin
            if (sel)
            begin
                last_count = `CDTF_LAST_HIGH;
            end
            else
            begin
                last_count = `CDTF_LAST_LOW;
            end
        end
    endfunction

    // True output level: clear overrides the divider state
    function out_level;
        input div;
        input clear;
        begin
            out_level = div & ~clear;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every pin
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sync1_q <= `CDTF_RST_SYNC;
            sync2_q <= `CDTF_RST_SYNC;
        end
        else
        begin
            sync1_q <= {clk_in_p, clk_in_n, clk_in_open,
                        out_gate | out_gate_open,
                        master_clear_n | master_clear_open,
                        ratio_sel | ratio_sel_open};
            sync2_q <= sync1_q;
        end
    end

    assign gate_want = sync2_q[2];
    assign clear_act = ~sync2_q[1];
    assign ratio_hi  = sync2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Recovered input clock
    cdtf_in_guard u_guard
    (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .in_p    (sync2_q[5]),
        .in_n    (sync2_q[4]),
        .in_open (sync2_q[3]),
        .level_q (),
        .rise_q  (in_rise),
        .fall_q  (in_fall)
    );

    assign edge_any = in_rise | in_fall;

    ////////////////////////////////////////////////////////////////////////////
    // Gate change waits for an input rise, then an input fall
    always @*
    begin
        gs_d   = gs_q;
        gate_d = gate_q;
        case (gs_q)
            GS_STEADY:
            begin
                if (gate_want != gate_q)
                begin
                    if (in_rise)
                    begin
                        gs_d = GS_WAIT_FALL;
                    end
                    else
                    begin
                        gs_d = GS_WAIT_RISE;
                    end
                end
            end
            GS_WAIT_RISE:
            begin
                if (gate_want == gate_q)
                begin
                    gs_d = GS_STEADY;                            // Change withdrawn
                end
                else if (in_rise)
                begin
                    gs_d = GS_WAIT_FALL;
                end
            end
            GS_WAIT_FALL:
            begin
                if (gate_want == gate_q)
                begin
                    gs_d = GS_STEADY;                            // Change withdrawn
                end
                else if (in_fall)
                begin
                    gate_d = gate_want;
                    gs_d   = GS_STEADY;
                end
            end
            default:
            begin
                gs_d = GS_STEADY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Applied gate and sequencer state
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            gate_q <= `CDTF_RST_GATE;
            gs_q   <= GS_STEADY;
        end
        else
        begin
            gate_q <= gate_d;
            gs_q   <= gs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Half-period counter: toggles after 3 or 5 input edges
    always @*
    begin
        cnt_d = cnt_q;
        div_d = div_q;
        if (clear_act || !gate_q)
        begin
            cnt_d = `CDTF_RST_CNT;
            div_d = `CDTF_RST_TRUE_OUT;
        end
        else if (edge_any)
        begin
            if (cnt_q >= last_count(ratio_hi))
            begin
                cnt_d = `CDTF_RST_CNT;
                div_d = ~div_q;
            end
            else
            begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider state
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cnt_q <= `CDTF_RST_CNT;
            div_q <= `CDTF_RST_TRUE_OUT;
        end
        else
        begin
            cnt_q <= cnt_d;
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pair, straight from flip-flops; clear forces it without an edge
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            q_true <= `CDTF_RST_TRUE_OUT;
            q_comp <= `CDTF_RST_COMP_OUT;
        end
        else
        begin
            q_true <= out_level(div_d, clear_act);
            q_comp <= ~out_level(div_d, clear_act);
        end
    end

endmodule

// file: verilog/cdtf_in_guard.v
// Input clock recovery with dead-input guard and edge pulses
`timescale 1ns/1ns
`include "cdtf_consts.vh"

module cdtf_in_guard
(
    input  wire sys_clk,
    input  wire reset_n,
    input  wire in_p,
    input  wire in_n,
    input  wire in_open,
    output reg  level_q,
    output reg  rise_q,
    output reg  fall_q
);

    reg  level_d;
    reg  lock_q;
    wire lock_d;

    // First real level after reset is adopted without an edge pulse
    assign lock_d = lock_q | in_open | (in_p != in_n);

    ////////////////////////////////////////////////////////////////////////////
    // Recovered level: a real differential swing moves it, an open input sets it high
    always @*
    begin
        level_d = level_q;
        if (in_open)
        begin
            level_d = `CDTF_OPEN_LEVEL;
        end
        else if (in_p != in_n)
        begin
            level_d = in_p;
        end
        // Equal legs mean a collapsed swing: hold, no toggling
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level register and one-cycle edge pulses
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            level_q <= `CDTF_RST_LEVEL;
            lock_q  <= 1'h0;
            rise_q  <= 1'h0;
            fall_q  <= 1'h0;
        end
        else
        begin
            level_q <= level_d;
            lock_q  <= lock_d;
            rise_q  <= lock_q & level_d & ~level_q;          // No false edge after reset
            fall_q  <= lock_q & ~level_d & level_q;
        end
    end

endmodule
